/* File: core/spb_sub_panel_bridge.sv */
/*
  Sub-panel packet bridge: parses register-access and video-stream
  payloads, routes them to the main panel port or, through a FIFO, to a
  parallel write-only bus generator for a sub-panel driver.
  Assumes link words and configuration come from logic on ref_clk.
*/
`timescale 1ns/1ps
module spb_sub_panel_bridge #(
  parameter logic [15:0] SEL_INDEX_INIT = spb_pkg::SEL_INDEX_RESET,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire spb_pkg::spb_link_word_t linkWord,
  input wire logic linkValid,
  output logic linkReady,
  input wire spb_pkg::spb_cfg_t panelCfg,
  input wire logic selIndexWe,
  input wire logic [15:0] selIndexWrData,
  input wire logic [15:0] videoStartIndex,
  input wire logic stnStartEnable,
  output logic mainRegWe,
  output logic [15:0] mainRegAddr,
  output logic [15:0] mainRegData,
  output logic mainPixelWe,
  output logic [17:0] mainPixel,
  output logic subPathActive,
  output logic busBusy,
  output logic chipSelectN,
  output logic secondaryRegisterSelect,
  output logic secondaryWriteStrobe,
  output logic [17:0] secondaryDataBus
);
  typedef enum logic [2:0] {P_TYPE, P_RWINFO, P_ADDR, P_DATA, P_PIXEL, P_SKIP} spb_pstate_t;
  typedef enum logic [1:0] {B_IDLE, B_SETUP, B_STROBE, B_HOLD} spb_bstate_t;

  spb_pstate_t pState, pNext;
  logic [15:0] addrReg, addrNext, selIndexReg, selIndexNext;
  logic rwOkReg, rwOkNext, selHitReg, selHitNext, toSubReg, toSubNext;
  logic subActiveReg, subActiveNext;
  logic mainRegWeNext, mainPixelWeNext;
  logic [15:0] mainRegAddrNext, mainRegDataNext;
  logic [17:0] mainPixelNext;
  logic take, pushWant, pushValid, fifoInReady;
  spb_pkg::spb_item_t pushItem, headItem;
  logic [19:0] headRaw;
  logic headValid, headPop;

  assign linkReady = !pushWant || fifoInReady;
  assign take = linkValid && linkReady;
  assign pushValid = take && pushWant;
  assign subPathActive = subActiveReg;

  // Packet parser and path routing
  always_comb begin
    pNext = pState;
    addrNext = addrReg;
    rwOkNext = rwOkReg;
    selHitNext = selHitReg;
    toSubNext = toSubReg;
    subActiveNext = subActiveReg;
    selIndexNext = selIndexWe ? selIndexWrData : selIndexReg;
    mainRegWeNext = 1'b0;
    mainPixelWeNext = 1'b0;
    mainRegAddrNext = mainRegAddr;
    mainRegDataNext = mainRegData;
    mainPixelNext = mainPixel;
    pushWant = 1'b0;
    pushItem = '0;
    unique case (pState)
      P_TYPE: begin
        toSubNext = subActiveReg;
        if (linkWord.data[15:0] == spb_pkg::TYPE_REG) begin
          pNext = P_RWINFO;
        end else if (linkWord.data[15:0] == spb_pkg::TYPE_VIDEO) begin
          pNext = P_PIXEL;
          if (subActiveReg && (!panelCfg.passive || stnStartEnable)) begin
            pushWant = 1'b1;
            pushItem.data = {2'h0, videoStartIndex};
          end
        end else begin
          pNext = P_SKIP;
        end
      end
      P_RWINFO: begin
        rwOkNext = (linkWord.data[15:0] == spb_pkg::RW_WRITE_INFO);
        pNext = P_ADDR;
      end
      P_ADDR: begin
        addrNext = linkWord.data[15:0];
        selHitNext = (linkWord.data[15:0] == selIndexReg);
        pNext = P_DATA;
        if (!selHitNext && rwOkReg && toSubReg && !panelCfg.passive) begin
          pushWant = 1'b1;
          pushItem.data = {2'h0, linkWord.data[15:0]};
        end
      end
      P_DATA: begin
        if (rwOkReg && selHitReg) begin
          subActiveNext = !linkWord.data[0];
        end else if (rwOkReg && toSubReg) begin
          pushWant = 1'b1;
          pushItem.regSel = panelCfg.passive ? addrReg[0] : 1'b1;
          pushItem.data = {2'h0, linkWord.data[15:0]};
        end else if (rwOkReg) begin
          mainRegWeNext = take;
          mainRegAddrNext = addrReg;
          mainRegDataNext = linkWord.data[15:0];
        end
      end
      P_PIXEL: begin
        if (toSubReg) begin
          pushWant = 1'b1;
          pushItem.regSel = 1'b1;
          pushItem.isVideo = 1'b1;
          pushItem.data = linkWord.data;
        end else begin
          mainPixelWeNext = take;
          mainPixelNext = linkWord.data;
        end
      end
      P_SKIP: begin
        pNext = P_SKIP;
      end
    endcase
    if (!take) begin
      pNext = pState;
      addrNext = addrReg;
      rwOkNext = rwOkReg;
      selHitNext = selHitReg;
      toSubNext = toSubReg;
      subActiveNext = subActiveReg;
      mainRegAddrNext = mainRegAddr;
      mainRegDataNext = mainRegData;
      mainPixelNext = mainPixel;
    end else if (linkWord.last) begin
      pNext = P_TYPE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pState <= P_TYPE;
      addrReg <= '0;
      rwOkReg <= 1'b0;
      selHitReg <= 1'b0;
      toSubReg <= 1'b0;
      subActiveReg <= 1'b0;
      selIndexReg <= SEL_INDEX_INIT;
      mainRegWe <= 1'b0;
      mainPixelWe <= 1'b0;
      mainRegAddr <= '0;
      mainRegData <= '0;
      mainPixel <= '0;
    end else begin
      pState <= pNext;
      addrReg <= addrNext;
      rwOkReg <= rwOkNext;
      selHitReg <= selHitNext;
      toSubReg <= toSubNext;
      subActiveReg <= subActiveNext;
      selIndexReg <= selIndexNext;
      mainRegWe <= mainRegWeNext;
      mainPixelWe <= mainPixelWeNext;
      mainRegAddr <= mainRegAddrNext;
      mainRegData <= mainRegDataNext;
      mainPixel <= mainPixelNext;
    end
  end

  spb_fifo #(.WIDTH(20), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .inValid(pushValid),
    .inReady(fifoInReady),
    .inData(pushItem),
    .outValid(headValid),
    .outReady(headPop),
    .outData(headRaw)
  );
  assign headItem = headRaw;

  // Lane placement of one beat on the sub-panel data bus
  function automatic logic [17:0] busWord(input spb_pkg::spb_item_t it, input logic second,
                                          input spb_pkg::spb_cfg_t cfg);
    logic narrow;
    narrow = (cfg.width == spb_pkg::WIDTH_9) || (cfg.width == spb_pkg::WIDTH_8);
    if (!it.isVideo && cfg.passive) begin
      return {it.data[7:0], 10'h000};
    end else if (narrow && it.isVideo && cfg.width == spb_pkg::WIDTH_9) begin
      return second ? {it.data[8:0], 9'h000} : {it.data[17:9], 9'h000};
    end else if (narrow) begin
      return second ? {it.data[7:0], 10'h000} : {it.data[15:8], 10'h000};
    end else if (it.isVideo && cfg.width == spb_pkg::WIDTH_18) begin
      return it.data;
    end
    return {it.data[15:8], 1'h0, it.data[7:0], 1'h0};
  endfunction : busWord

  spb_bstate_t bState, bNext;
  logic [7:0] phaseReg, phaseNext;
  logic secondReg, secondNext, csNReg, csNNext, rsReg, rsNext, strobeActReg, strobeActNext;
  logic [17:0] dataReg, dataNext;
  logic twoBeats;

  assign twoBeats = (panelCfg.width == spb_pkg::WIDTH_9 || panelCfg.width == spb_pkg::WIDTH_8)
                    && (headItem.isVideo || !panelCfg.passive);
  assign headPop = (bState == B_HOLD) && (phaseReg == '0) && (!twoBeats || secondReg);
  assign busBusy = (bState != B_IDLE);
  assign chipSelectN = csNReg;
  assign secondaryRegisterSelect = rsReg;
  assign secondaryDataBus = dataReg;
  // 68 style drives an active-high enable; 80 style an active-low write
  assign secondaryWriteStrobe = (panelCfg.style68 && !panelCfg.passive) ? strobeActReg
                                : !strobeActReg;

  // Write-cycle generator, one beat per setup/strobe/hold sequence
  always_comb begin
    bNext = bState;
    phaseNext = (phaseReg != '0) ? phaseReg - 1'b1 : phaseReg;
    secondNext = secondReg;
    csNNext = csNReg;
    rsNext = rsReg;
    strobeActNext = strobeActReg;
    dataNext = dataReg;
    unique case (bState)
      B_IDLE: begin
        if (headValid) begin
          bNext = B_SETUP;
          phaseNext = spb_pkg::SETUP_CYC - 1'b1;
          csNNext = 1'b0;
          rsNext = headItem.regSel;
          dataNext = busWord(headItem, 1'b0, panelCfg);
        end
      end
      B_SETUP: begin
        if (phaseReg == '0) begin
          bNext = B_STROBE;
          phaseNext = spb_pkg::STROBE_CYC - 1'b1;
          strobeActNext = 1'b1;
        end
      end
      B_STROBE: begin
        if (phaseReg == '0) begin
          bNext = B_HOLD;
          phaseNext = spb_pkg::HOLD_CYC - 1'b1;
          strobeActNext = 1'b0;
        end
      end
      B_HOLD: begin
        if (phaseReg == '0) begin
          if (twoBeats && !secondReg) begin
            bNext = B_SETUP;
            phaseNext = spb_pkg::SETUP_CYC - 1'b1;
            secondNext = 1'b1;
            dataNext = busWord(headItem, 1'b1, panelCfg);
          end else begin
            bNext = B_IDLE;
            secondNext = 1'b0;
            csNNext = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bState <= B_IDLE;
      phaseReg <= '0;
      secondReg <= 1'b0;
      csNReg <= 1'b1;
      rsReg <= 1'b0;
      strobeActReg <= 1'b0;
      dataReg <= '0;
    end else begin
      bState <= bNext;
      phaseReg <= phaseNext;
      secondReg <= secondNext;
      csNReg <= csNNext;
      rsReg <= rsNext;
      strobeActReg <= strobeActNext;
      dataReg <= dataNext;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_strobe_in_cs;
    strobeActReg |-> !chipSelectN;
  endproperty
  a_strobe_in_cs: assert property (p_strobe_in_cs) else $error("strobe outside chip select");

  property p_strobe_len;
    $rose(strobeActReg) |-> strobeActReg[*5] ##1 !strobeActReg;
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe width wrong");

  property p_data_stable;
    strobeActReg |-> $stable(secondaryDataBus) && $stable(secondaryRegisterSelect);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("bus changed in strobe");

  property p_style68;
    panelCfg.style68 && !panelCfg.passive && $rose(strobeActReg) |-> secondaryWriteStrobe;
  endproperty
  a_style68: assert property (p_style68) else $error("68 enable not high");

  property p_style80;
    (panelCfg.passive || !panelCfg.style68) |-> (secondaryWriteStrobe == (bState != B_STROBE));
  endproperty
  a_style80: assert property (p_style80) else $error("80 write polarity wrong");

  property p_wide_lanes;
    !chipSelectN && !panelCfg.passive && panelCfg.width == spb_pkg::WIDTH_16
      |-> secondaryDataBus[9] == 1'b0 && secondaryDataBus[0] == 1'b0;
  endproperty
  a_wide_lanes: assert property (p_wide_lanes) else $error("16-bit lanes wrong");

  property p_narrow_lanes;
    !chipSelectN && panelCfg.width == spb_pkg::WIDTH_8 |-> secondaryDataBus[9:0] == 10'h000;
  endproperty
  a_narrow_lanes: assert property (p_narrow_lanes) else $error("8-bit lanes wrong");

  property p_select;
    take && pState == P_DATA && selHitReg && rwOkReg |=> subActiveReg == !$past(linkWord.data[0]);
  endproperty
  a_select: assert property (p_select) else $error("path select wrong");

  property p_video_cmd;
    take && pState == P_TYPE && linkWord.data[15:0] == spb_pkg::TYPE_VIDEO && subActiveReg
      && !panelCfg.passive |-> pushValid && pushItem.data[15:0] == videoStartIndex && !pushItem.regSel;
  endproperty
  a_video_cmd: assert property (p_video_cmd) else $error("no start command");

  property p_stn_rs;
    pushValid && panelCfg.passive && pState == P_DATA |-> pushItem.regSel == addrReg[0];
  endproperty
  a_stn_rs: assert property (p_stn_rs) else $error("passive select wrong");

  c_sub_select: cover property (take && pState == P_DATA && selHitReg && !linkWord.data[0]);
  c_two_beats: cover property ($rose(secondReg));
  c_style68: cover property (panelCfg.style68 && strobeActReg);
  c_stn_push: cover property (pushValid && panelCfg.passive);
endmodule : spb_sub_panel_bridge

/* File: core/spb_pkg.sv */
/*
  Shared constants and carrier types for the sub-panel packet bridge.
  Assumes the link packet layer delivers decoded payload words on the
  bridge clock (100 MHz) with length and CRC fields already removed.
*/
// Notes on behaviour
// - Sub-panel packets become parallel 68/80 write cycles
// - Bus widths 18, 16, 9, 8 only
// - Selection index data bit0 zero selects sub path
// - Insert memory-write command before pixel data
// - TFT 18/16 register data on [17:10],[8:1]
// - 9/8 bit: upper byte then lower on [17:10]
// - 68 style write only, far read/write held low
// - TFT timing; style bit 1 means 68 cycles
// - Width taken from width-select field
// - Passive panel uses 80 style only
// - Passive instructions always 8 bits wide
// - Passive register select copies address bit0
// - Instruction byte low, parameter bytes high select
// - Passive 16-bit video over 8 bits: two bytes
// - Register packet recognised by type 146
// - Video packet recognised by type 16, in order
package spb_pkg;
  localparam logic [15:0] TYPE_REG = 16'h0092;
  localparam logic [15:0] TYPE_VIDEO = 16'h0010;
  localparam logic [15:0] RW_WRITE_INFO = 16'h0000;
  localparam logic [15:0] SEL_INDEX_RESET = 16'h0053;
  localparam logic [15:0] MEM_WRITE_INDEX = 16'h0022;
  localparam logic [1:0] WIDTH_18 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_9 = 2'h2;
  localparam logic [1:0] WIDTH_8 = 2'h3;
  localparam int CLK_FREQ_MHZ = 100;
  localparam int SETUP_NS = 20;
  localparam int STROBE_NS = 50;
  localparam int HOLD_NS = 20;
  localparam logic [7:0] SETUP_CYC = 8'((SETUP_NS * CLK_FREQ_MHZ + 999) / 1000);
  localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS * CLK_FREQ_MHZ + 999) / 1000);
  localparam logic [7:0] HOLD_CYC = 8'((HOLD_NS * CLK_FREQ_MHZ + 999) / 1000);

  typedef struct packed {
    logic last;
    logic [17:0] data;
  } spb_link_word_t;

  typedef struct packed {
    logic regSel;
    logic isVideo;
    logic [17:0] data;
  } spb_item_t;

  typedef struct packed {
    logic passive;
    logic style68;
    logic [1:0] width;
  } spb_cfg_t;
endpackage : spb_pkg

/* File: core/spb_fifo.sv */
/*
  Parameterised FIFO with valid/ready on both sides; head word is held
  in an output register. DEPTH must be a power of two.
*/
`timescale 1ns/1ps
module spb_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrReg, wrNext, rdReg, rdNext;
  logic [AW:0] countReg, countNext;
  logic [WIDTH-1:0] outReg, outNext;
  logic outValidReg, outValidNext;
  logic push, load;

  assign inReady = (countReg != FULL_COUNT);
  assign push = inValid && inReady;
  assign load = (countReg != '0) && (!outValidReg || outReady);
  assign outValid = outValidReg;
  assign outData = outReg;

  always_comb begin
    wrNext = push ? wrReg + 1'b1 : wrReg;
    rdNext = load ? rdReg + 1'b1 : rdReg;
    countNext = countReg;
    if (push && !load) begin
      countNext = countReg + 1'b1;
    end else if (load && !push) begin
      countNext = countReg - 1'b1;
    end
    outNext = load ? mem[rdReg] : outReg;
    outValidNext = load ? 1'b1 : (outReady ? 1'b0 : outValidReg);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrReg <= '0;
      rdReg <= '0;
      countReg <= '0;
      outReg <= '0;
      outValidReg <= 1'b0;
    end else begin
      wrReg <= wrNext;
      rdReg <= rdNext;
      countReg <= countNext;
      outReg <= outNext;
      outValidReg <= outValidNext;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrReg] <= inData;
    end
  end
endmodule : spb_fifo

/* File: tb/spb_sub_panel_model.sv */
/*
  Sub-panel driver model: a write-only parallel sink that latches
  register select and data on the trailing edge of each strobe made with chip select low.
  Assumes bridge outputs are settled by the falling edge of ref_clk.
*/
`timescale 1ns/1ps
module spb_sub_panel_model (
  input wire logic ref_clk,
  input wire logic style68,
  input wire logic chipSelectN,
  input wire logic secondaryRegisterSelect,
  input wire logic secondaryWriteStrobe,
  input wire logic [17:0] secondaryDataBus
);
  logic farReadWrite;
  logic strobeActive;
  logic strobeWasActive = 1'b0;
  logic [18:0] capQ[$];
  int strayCount = 0;
  // Read/write input tied low: this chip only ever accepts writes
  assign farReadWrite = 1'b0;
  // Enable is active high in 68 style, strobe active low otherwise
  assign strobeActive = style68 ? secondaryWriteStrobe : !secondaryWriteStrobe;
  // A strobe without chip select is counted, never latched
  always @(negedge ref_clk) begin
    if (strobeWasActive && !strobeActive && !farReadWrite) begin
      if (chipSelectN === 1'b0)
        capQ.push_back({secondaryRegisterSelect, secondaryDataBus});
      else
        strayCount++;
    end
    strobeWasActive <= strobeActive;
  end
endmodule : spb_sub_panel_model

/* File: tb/spb_sub_panel_bridge_tb.sv */
/*
  Self-checking bench for the sub-panel packet bridge: sends link
  packets, checks main-path writes and the beats seen by the model.
  Assumes the bridge, its FIFO and the package are compiled first.
*/
`timescale 1ns/1ps
module spb_sub_panel_bridge_tb;
  logic ref_clk;
  logic rst_n;
  spb_pkg::spb_link_word_t linkWord;
  logic linkValid, linkReady, selIndexWe, stnStartEnable;
  spb_pkg::spb_cfg_t panelCfg;
  logic [15:0] selIndexWrData, videoStartIndex, mainRegAddr, mainRegData;
  logic mainRegWe, mainPixelWe, subPathActive, busBusy, sawFull;
  logic chipSelectN, secondaryRegisterSelect, secondaryWriteStrobe;
  logic [17:0] mainPixel, secondaryDataBus;
  logic [31:0] mainQ[$];
  logic [17:0] pixQ[$];
  logic [18:0] expQ[$];
  int bad_count, checks_done, cycles;

  spb_sub_panel_bridge spb_sub_panel_bridge_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .linkWord(linkWord), .linkValid(linkValid), .linkReady(linkReady), .panelCfg(panelCfg),
    .selIndexWe(selIndexWe), .selIndexWrData(selIndexWrData),
    .videoStartIndex(videoStartIndex), .stnStartEnable(stnStartEnable),
    .mainRegWe(mainRegWe), .mainRegAddr(mainRegAddr), .mainRegData(mainRegData),
    .mainPixelWe(mainPixelWe), .mainPixel(mainPixel), .subPathActive(subPathActive),
    .busBusy(busBusy), .chipSelectN(chipSelectN),
    .secondaryRegisterSelect(secondaryRegisterSelect),
    .secondaryWriteStrobe(secondaryWriteStrobe), .secondaryDataBus(secondaryDataBus));

  spb_sub_panel_model spb_sub_panel_model_i (.ref_clk(ref_clk),
    .style68(panelCfg.style68 && !panelCfg.passive), .chipSelectN(chipSelectN),
    .secondaryRegisterSelect(secondaryRegisterSelect),
    .secondaryWriteStrobe(secondaryWriteStrobe), .secondaryDataBus(secondaryDataBus));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Main-path pulses and FIFO back-pressure seen at settled times
  always @(negedge ref_clk) begin
    if (mainRegWe === 1'b1) mainQ.push_back({mainRegAddr, mainRegData});
    if (mainPixelWe === 1'b1) pixQ.push_back(mainPixel);
    if (linkValid && linkReady === 1'b0) sawFull = 1'b1;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic final_report;
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic check(input logic [35:0] seen, input logic [35:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s seen=%h exp=%h", $time, what, seen, exp);
    end
  endtask : check

  // One link word, held until the edge that takes it
  task automatic send_word(input logic last, input logic [17:0] data);
    @(negedge ref_clk);
    linkWord = {last, data};
    linkValid = 1'b1;
    #1;
    while (linkReady !== 1'b1) begin
      @(negedge ref_clk);
      #1;
    end
    // Taken at the rising edge in between; released a half cycle later
    @(negedge ref_clk);
    linkValid = 1'b0;
  endtask : send_word

  task automatic send_reg(input logic [15:0] addr, input logic [15:0] data,
                          input logic [15:0] rwInfo = spb_pkg::RW_WRITE_INFO);
    send_word(1'b0, {2'b00, spb_pkg::TYPE_REG});
    send_word(1'b0, {2'b00, rwInfo});
    send_word(1'b0, {2'b00, addr});
    send_word(1'b1, {2'b00, data});
    repeat (4) @(negedge ref_clk);
  endtask : send_reg

  function automatic logic [17:0] pix(input int i);
    return 18'(32'h0002_A5C3 + i * 32'h0000_1111);
  endfunction : pix

  task automatic send_video(input int n);
    send_word(1'b0, {2'b00, spb_pkg::TYPE_VIDEO});
    for (int i = 0; i < n; i++) send_word(i == n - 1, pix(i));
  endtask : send_video

  // Expected beats for one item under the current width setting
  task automatic exp_item(input logic rs, input logic [17:0] d, input logic vid);
    logic [17:0] lay;
    lay = {d[15:8], 1'b0, d[7:0], 1'b0};
    case (panelCfg.width)
      spb_pkg::WIDTH_18: expQ.push_back({rs, vid ? d : lay});
      spb_pkg::WIDTH_16: expQ.push_back({rs, lay});
      spb_pkg::WIDTH_9: begin
        expQ.push_back(vid ? {rs, d[17:9], 9'h000} : {rs, d[15:8], 10'h000});
        expQ.push_back(vid ? {rs, d[8:0], 9'h000} : {rs, d[7:0], 10'h000});
      end
      default: begin
        expQ.push_back({rs, d[15:8], 10'h000});
        expQ.push_back({rs, d[7:0], 10'h000});
      end
    endcase
  endtask : exp_item

  task automatic compare_sub;
    while (spb_sub_panel_model_i.capQ.size() < expQ.size()) begin
      @(negedge ref_clk);
    end
    repeat (30) @(negedge ref_clk);
    check(spb_sub_panel_model_i.capQ.size(), expQ.size(), "beat count");
    foreach (expQ[i]) check(spb_sub_panel_model_i.capQ[i], expQ[i], "beat");
    check(busBusy, 1'b0, "engine idle");
    spb_sub_panel_model_i.capQ.delete();
    expQ.delete();
  endtask : compare_sub

  initial begin
    rst_n = 1'b0;
    linkWord = '0;
    linkValid = 1'b0;
    panelCfg = '0;
    selIndexWe = 1'b0;
    selIndexWrData = 16'h0000;
    videoStartIndex = spb_pkg::MEM_WRITE_INDEX;
    stnStartEnable = 1'b0;
    sawFull = 1'b0;
    bad_count = 0;
    checks_done = 0;
    cycles = 0;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    check({chipSelectN, secondaryWriteStrobe, subPathActive, linkReady}, 4'hD, "reset");
    rst_n = 1'b1;
    // Main path: write, ignored read, pixels
    send_reg(16'h0010, 16'h1234);
    send_reg(16'h0011, 16'h5678, 16'hC000);
    send_word(1'b0, 18'h0_0099);
    send_word(1'b1, 18'h0_0010);
    send_video(2);
    repeat (4) @(negedge ref_clk);
    check(mainQ.size(), 1, "main writes");
    check(mainQ[0], 32'h0010_1234, "main write");
    check(pixQ.size(), 2, "main pixels");
    foreach (pixQ[i]) check(pixQ[i], pix(i), "main pixel");
    send_reg(spb_pkg::SEL_INDEX_RESET, 16'h0000);
    check(subPathActive, 1'b1, "sub selected");
    // TFT: both bus styles, every width
    for (int s = 0; s < 2; s++) begin
      for (int w = 0; w < 4; w++) begin
        panelCfg = {1'b0, 1'(s), 2'(w)};
        send_reg(16'h0044, 16'hA55A);
        exp_item(1'b0, 18'h0_0044, 1'b0);
        exp_item(1'b1, 18'h0_A55A, 1'b0);
        send_video(2);
        exp_item(1'b0, {2'b00, spb_pkg::MEM_WRITE_INDEX}, 1'b0);
        for (int i = 0; i < 2; i++) exp_item(1'b1, pix(i), 1'b1);
        compare_sub();
      end
    end
    // FIFO fills and back-pressures the link while the bus drains
    panelCfg = {1'b0, 1'b0, spb_pkg::WIDTH_8};
    send_video(40);
    exp_item(1'b0, {2'b00, spb_pkg::MEM_WRITE_INDEX}, 1'b0);
    for (int i = 0; i < 40; i++) exp_item(1'b1, pix(i), 1'b1);
    compare_sub();
    check(sawFull, 1'b1, "link stalled");
    // Passive panel: 8-bit instructions, select from address bit 0
    panelCfg = {1'b1, 1'b0, spb_pkg::WIDTH_8};
    send_reg(16'h0000, 16'h0038);
    send_reg(16'h0001, 16'h00AB);
    expQ.push_back({1'b0, 8'h38, 10'h000});
    expQ.push_back({1'b1, 8'hAB, 10'h000});
    send_video(1);
    exp_item(1'b1, pix(0), 1'b1);
    compare_sub();
    stnStartEnable = 1'b1;
    videoStartIndex = 16'h002C;
    send_video(1);
    expQ.push_back({1'b0, 8'h2C, 10'h000});
    exp_item(1'b1, pix(0), 1'b1);
    compare_sub();
    // Relocated selection index returns to the main path
    @(negedge ref_clk);
    selIndexWe = 1'b1;
    selIndexWrData = 16'h0060;
    @(negedge ref_clk);
    selIndexWe = 1'b0;
    send_reg(16'h0060, 16'h0001);
    check(subPathActive, 1'b0, "main selected");
    send_reg(16'h0012, 16'h00FE);
    repeat (4) @(negedge ref_clk);
    check(mainQ[$], 32'h0012_00FE, "main again");
    check(spb_sub_panel_model_i.strayCount, 0, "stray strobes");
    final_report();
  end
endmodule : spb_sub_panel_bridge_tb
